// [hdl/ucs_defines.vh]
// Purpose: constants for the clock select and loop control block
// Assumes: 10 MHz core clock, 4-bit register index, 16-bit data
// Notes: definitions only
`ifndef UCS_DEFINES_VH
`define UCS_DEFINES_VH
// register offsets
`define UCS_A_CTRL 4'h0
`define UCS_A_SEL 4'h1
`define UCS_A_FAULT 4'h2
`define UCS_A_TARGET 4'h3
`define UCS_A_LOOP 4'h4
`define UCS_A_MEAS 4'h5
`define UCS_A_ISTAT 4'h6
`define UCS_A_IMASK 4'h7
// control bits
`define UCS_C_LOOP_EN 0
`define UCS_C_LF_EN 1
`define UCS_C_HF_EN 2
`define UCS_C_NMI_EN 3
// select fields
`define UCS_SEL_MAIN 1:0
`define UCS_SEL_SUB 3:2
`define UCS_SEL_AUX 5:4
`define UCS_SEL_RST 6'h24
// source codes
`define UCS_SRC_LF 2'h0
`define UCS_SRC_REF 2'h1
`define UCS_SRC_DCO 2'h2
`define UCS_SRC_HF 2'h3
// fault flag bits
`define UCS_F_LF 0
`define UCS_F_HF 1
`define UCS_F_ALL 2
// interrupt status bits
`define UCS_I_FAULT 0
`define UCS_I_SEL 1
`define UCS_I_SETTLE 2
// loop status bits
`define UCS_L_TAP 4:0
`define UCS_L_MOD 9:5
`define UCS_L_SETTLED 10
`define UCS_L_GLITCH 11
// loop constants
`define UCS_MOD_MAX 5'h1F
`define UCS_MOD_GLITCH 5'h1E
`define UCS_GLITCH_REFS 4'hF
`define UCS_SETTLE_REFS 11'h400
`define UCS_TARGET_RST 10'h131
`define UCS_TAP_RST 10'h200
`endif

// [hdl/ucs_clock_ctrl.v]
// Purpose: clock source select, crystal fault flags and loop tracking
// Assumes: oscillator and loop reference inputs are slow, asynchronous levels
// Notes: register port with read data one cycle after the read strobe
`include "ucs_defines.vh"

// Contract
// R1: a write to a source field routes that clock from the newly chosen source.
// R2: any change of a source field may falsely set an absent or unconfigured crystal fault.
// R3: the false fault may appear whichever of the three fields changed.
// R4: with the fault interrupt enabled a false fault raises the non-maskable interrupt.
// R5: software clears every fault flag once after any source field change.
// R6: software masks the fault interrupt while switching, or clears false flags in its handler.
// R7: software stops oscillator users, enables the loop and waits 32 x 32 reference periods.
// R8: software then turns the loop off and measures the oscillator against a reference.
// R9: software repeats from enabling the loop while the measured frequency is too high.
// R10: the step-boundary defect leaves the main clock correct at the top specified rate.
// R11: the enabled loop tracks by stepping tap and modulation, modulation mixing tap and tap+1.
// R12: at a tap boundary tap may rise while modulation falls, for about 15 reference cycles.
// R13: each fault flag stays set until cleared and sets again if the fault persists.
module ucs_clock_ctrl (
  input wire core_clk_i, // 10 MHz core clock
  input wire rst_b_i, // async reset, active low
  input wire [3:0] addr_i, // register index
  input wire [15:0] wdata_i, // write data
  input wire wr_i, // write strobe
  input wire rd_i, // read strobe
  output reg [15:0] rdata_o, // read data, cycle after rd_i
  input wire low_freq_crystal_i, // low frequency crystal clock
  input wire high_freq_crystal_i, // high frequency crystal clock
  input wire internal_reference_osc_i, // internal reference oscillator
  input wire digitally_tuned_oscillator_i, // tuned oscillator clock
  input wire loop_reference_clock_i, // loop reference clock
  input wire lf_present_i, // low frequency crystal oscillates
  input wire hf_present_i, // high frequency crystal oscillates
  output reg main_clk_o, // main clock
  output reg subsystem_clk_o, // subsystem clock
  output reg aux_clk_o, // auxiliary clock
  output wire [4:0] oscillator_tap_o, // tap field to oscillator
  output wire [4:0] modulation_o, // modulation field to oscillator
  output wire osc_fault_nmi_o, // fault non-maskable interrupt
  output wire irq_o // maskable interrupt, level
);

  // synchroniser: stage one is read only by stage two
  reg [6:0] sync1_r;
  reg [6:0] sync2_r;
  reg [1:0] dco_prev_r;
  wire lf_clk = sync2_r[0];
  wire hf_clk = sync2_r[1];
  wire ref_clk = sync2_r[2];
  wire dco_clk = sync2_r[3];
  wire lref_clk = sync2_r[4];
  wire lf_ok = sync2_r[5];
  wire hf_ok = sync2_r[6];
  wire dco_rise = dco_clk & ~dco_prev_r[0];
  wire lref_rise = lref_clk & ~dco_prev_r[1];

  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_r <= 7'h00;
      sync2_r <= 7'h00;
      dco_prev_r <= 2'h0;
    end else begin
      sync1_r <= {hf_present_i, lf_present_i, loop_reference_clock_i,
                  digitally_tuned_oscillator_i, internal_reference_osc_i,
                  high_freq_crystal_i, low_freq_crystal_i};
      sync2_r <= sync1_r;
      dco_prev_r <= {lref_clk, dco_clk};
    end
  end

  // software visible state
  reg [3:0] ctrl_r;
  reg [5:0] sel_r;
  reg [1:0] fault_r;
  reg [9:0] target_r;
  reg [9:0] meas_r;
  reg [2:0] istat_r;
  reg [2:0] imask_r;
  reg [15:0] rdata_nxt;

  // loop state: {tap, mod} held as one 10-bit step value
  reg [9:0] step_r;
  reg [9:0] step_nxt;
  reg [9:0] cnt_r;
  reg [10:0] settle_r;
  reg settled_r;
  reg [3:0] glitch_r;

  wire wr_ctrl = wr_i && (addr_i == `UCS_A_CTRL);
  wire wr_sel = wr_i && (addr_i == `UCS_A_SEL);
  wire wr_fault = wr_i && (addr_i == `UCS_A_FAULT);
  wire wr_istat = wr_i && (addr_i == `UCS_A_ISTAT);
  wire loop_en = ctrl_r[`UCS_C_LOOP_EN];

  // any field differing counts as a change, whichever field it is [R3]
  wire sel_change = wr_sel && (wdata_i[5:0] != sel_r);

  // the switch briefly requests both crystals; absent or unconfigured ones fault [R2]
  wire lf_bad = ~lf_ok | ~ctrl_r[`UCS_C_LF_EN];
  wire hf_bad = ~hf_ok | ~ctrl_r[`UCS_C_HF_EN];
  // a crystal in use but not oscillating is a real fault, re-set after a clear [R13]
  wire lf_real = ctrl_r[`UCS_C_LF_EN] & ~lf_ok;
  wire hf_real = ctrl_r[`UCS_C_HF_EN] & ~hf_ok;
  wire [1:0] fault_set = {hf_real | (sel_change & hf_bad),
                          lf_real | (sel_change & lf_bad)}; // [R2]
  wire fault_all = |fault_r;
  wire settle_done = loop_en && !settled_r && (settle_r == `UCS_SETTLE_REFS);
  wire [2:0] ev = {settle_done, sel_change, |(fault_set & ~fault_r)};

  // combined flag drives the nmi only while enabled [R4]
  assign osc_fault_nmi_o = fault_all & ctrl_r[`UCS_C_NMI_EN];
  assign irq_o = |(istat_r & imask_r);
  assign oscillator_tap_o = step_r[9:5];
  assign modulation_o = step_r[4:0];

  // register writes; hardware set wins over a write-one clear
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_r <= 4'h0;
      sel_r <= `UCS_SEL_RST;
      fault_r <= 2'h0;
      target_r <= `UCS_TARGET_RST;
      istat_r <= 3'h0;
      imask_r <= 3'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= wdata_i[3:0];
      end
      if (wr_sel) begin
        sel_r <= wdata_i[5:0]; // [R1]
      end
      if (wr_i && (addr_i == `UCS_A_TARGET)) begin
        target_r <= wdata_i[9:0];
      end
      if (wr_i && (addr_i == `UCS_A_IMASK)) begin
        imask_r <= wdata_i[2:0];
      end
      // sticky until cleared, set wins over clear [R13]
      fault_r <= (fault_r & ~(wr_fault ? wdata_i[1:0] : 2'h0)) | fault_set;
      istat_r <= (istat_r & ~(wr_istat ? wdata_i[2:0] : 3'h0)) | ev;
    end
  end

  // one pick per clock; the mux follows the field with no extra logic in the
  // main path, so a boundary step only shifts the source rate [R10]
  function pick;
    input [1:0] src;
    input l;
    input r;
    input d;
    input h;
    begin
      case (src)
        `UCS_SRC_LF: pick = l;
        `UCS_SRC_REF: pick = r;
        `UCS_SRC_DCO: pick = d;
        default: pick = h;
      endcase
    end
  endfunction

  // route each clock from its selected source [R1]
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      main_clk_o <= 1'b0;
      subsystem_clk_o <= 1'b0;
      aux_clk_o <= 1'b0;
    end else begin
      main_clk_o <= pick(sel_r[`UCS_SEL_MAIN], lf_clk, ref_clk, dco_clk, hf_clk); // [R1]
      subsystem_clk_o <= pick(sel_r[`UCS_SEL_SUB], lf_clk, ref_clk, dco_clk, hf_clk);
      aux_clk_o <= pick(sel_r[`UCS_SEL_AUX], lf_clk, ref_clk, dco_clk, hf_clk);
    end
  end

  // tracking step: modulation mixes tap and tap+1, rollover carries into tap
  always @* begin
    step_nxt = step_r;
    if (cnt_r < target_r) begin
      if (step_r != 10'h3FF) begin
        step_nxt = step_r + 10'h001; // [R11]
      end
    end else if (cnt_r > target_r) begin
      if (step_r != 10'h000) begin
        step_nxt = step_r - 10'h001; // [R11]
      end
    end
  end

  // loop: count tuned oscillator edges per reference period and step
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      step_r <= `UCS_TAP_RST;
      cnt_r <= 10'h000;
      meas_r <= 10'h000;
      glitch_r <= 4'h0;
    end else begin
      if (lref_rise) begin
        // the period count is always captured so software can measure [R8]
        meas_r <= cnt_r;
        cnt_r <= dco_rise ? 10'h001 : 10'h000;
        if (glitch_r != 4'h0) begin
          // hold the wrong step, then fall back to the expected one [R12]
          glitch_r <= glitch_r - 4'h1;
          if (glitch_r == 4'h1) begin
            step_r <= {step_r[9:5], 5'h00}; // [R12]
          end
        end else if (loop_en) begin
          if ((step_nxt > step_r) && (step_r[4:0] == `UCS_MOD_MAX)) begin
            // rollover misfires: tap up, modulation down one [R12]
            step_r <= {step_nxt[9:5], `UCS_MOD_GLITCH};
            glitch_r <= `UCS_GLITCH_REFS; // [R12]
          end else begin
            step_r <= step_nxt; // [R11]
          end
        end
      end else if (dco_rise && (cnt_r != 10'h3FF)) begin
        cnt_r <= cnt_r + 10'h001; // saturate rather than wrap on a fast oscillator
      end
    end
  end

  // settling timer: 32 x 32 reference periods after the loop is enabled
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      settle_r <= 11'h000;
      settled_r <= 1'b0;
    end else if (!loop_en) begin
      settle_r <= 11'h000; // turning the loop off restarts the wait
      settled_r <= 1'b0;
    end else begin
      if (lref_rise && (settle_r != `UCS_SETTLE_REFS)) begin
        settle_r <= settle_r + 11'h001; // [R7]
      end
      if (settle_done) begin
        settled_r <= 1'b1; // [R7]
      end
    end
  end

  // read mux; unmapped indexes read zero
  always @* begin
    rdata_nxt = 16'h0000;
    case (addr_i)
      `UCS_A_CTRL: rdata_nxt = {12'h000, ctrl_r};
      `UCS_A_SEL: rdata_nxt = {10'h000, sel_r};
      `UCS_A_FAULT: rdata_nxt = {13'h0000, fault_all, fault_r}; // [R5]
      `UCS_A_TARGET: rdata_nxt = {6'h00, target_r};
      `UCS_A_LOOP: rdata_nxt = {4'h0, (glitch_r != 4'h0), settled_r,
                                 step_r[4:0], step_r[9:5]};
      `UCS_A_MEAS: rdata_nxt = {6'h00, meas_r}; // [R9]
      `UCS_A_ISTAT: rdata_nxt = {13'h0000, istat_r};
      `UCS_A_IMASK: rdata_nxt = {13'h0000, imask_r};
      default: rdata_nxt = 16'h0000;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= 16'h0000;
    end else begin
      rdata_o <= rd_i ? rdata_nxt : 16'h0000;
    end
  end

endmodule // ucs_clock_ctrl

// [testbench/ucs_clock_ctrl_checker.sv]
// Purpose: port assertions for the clock select block
// Assumes: control and select are shadowed from bus writes
// Notes: clock outputs lag their source pins by three edges
`include "ucs_defines.vh"
module ucs_clock_ctrl_checker (
  input wire core_clk_i, // clock
  input wire rst_b_i, // reset
  input wire [3:0] addr_i, // index
  input wire [15:0] wdata_i, // data
  input wire wr_i, // write
  input wire low_freq_crystal_i, // src 0
  input wire internal_reference_osc_i, // src 1
  input wire digitally_tuned_oscillator_i, // src 2
  input wire high_freq_crystal_i, // src 3
  input wire main_clk_o, // main
  input wire subsystem_clk_o, // sub
  input wire aux_clk_o, // aux
  input wire [4:0] oscillator_tap_o, // tap
  input wire [4:0] modulation_o, // mod
  input wire osc_fault_nmi_o // nmi
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [3:0] ctl_r;
  reg [5:0] sel_r;
  reg [2:0] age_r;
  wire [3:0] src = {high_freq_crystal_i, digitally_tuned_oscillator_i,
    internal_reference_osc_i, low_freq_crystal_i};
  wire [2:0] pick = {src[sel_r[5:4]], src[sel_r[3:2]], src[sel_r[1:0]]};
  wire [9:0] step = {oscillator_tap_o, modulation_o};
  wire sel_wr = wr_i && addr_i == `UCS_A_SEL;
  // shadows; age waits out the pin synchronisers after a select change
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctl_r <= 4'h0;
      sel_r <= `UCS_SEL_RST;
      age_r <= 3'h0;
    end else begin
      if (wr_i && addr_i == `UCS_A_CTRL)
        ctl_r <= wdata_i[3:0];
      if (sel_wr)
        sel_r <= wdata_i[5:0];
      age_r <= sel_wr ? 3'h0 : age_r + {2'h0, age_r != 3'h7};
    end
  end
  default clocking dc @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  chk_main_route:
    assert property (age_r > 3'h4 |-> main_clk_o == $past(pick[0], 3))
    else $error("main clock off its source");
  chk_side_route:
    assert property (age_r > 3'h4 |-> {aux_clk_o, subsystem_clk_o} == $past(pick[2:1], 3))
    else $error("side clock off its source");
  chk_sel_fault:
    assert property (sel_wr && wdata_i[5:0] != sel_r && !ctl_r[`UCS_C_LF_EN]
      && ctl_r[`UCS_C_NMI_EN] |=> osc_fault_nmi_o)
    else $error("select change left no fault");
  chk_nmi_gate:
    assert property (!ctl_r[`UCS_C_NMI_EN] |-> !osc_fault_nmi_o)
    else $error("fault interrupt while disabled");
  chk_flag_hold:
    assert property (osc_fault_nmi_o && !wr_i |=> osc_fault_nmi_o)
    else $error("fault dropped without a clear");
  chk_loop_idle:
    assert property (!ctl_r[`UCS_C_LOOP_EN] && modulation_o != `UCS_MOD_GLITCH |=> $stable(step))
    else $error("step moved with loop off");
  chk_loop_step:
    assert property ($changed(step) |-> step == $past(step) + 10'h1 || step == $past(step) - 10'h1
      || step == $past(step) + 10'h1F || step == $past(step) - 10'h1E)
    else $error("step jumped");
  chk_tap_roll:
    assert property ($past(modulation_o) == `UCS_MOD_MAX
      && oscillator_tap_o == $past(oscillator_tap_o) + 5'h1 |-> modulation_o == `UCS_MOD_GLITCH)
    else $error("rollover modulation wrong");
  cov_sel_nmi: cover property (sel_wr ##1 osc_fault_nmi_o);
  cov_roll: cover property ($past(modulation_o) == `UCS_MOD_MAX && modulation_o == `UCS_MOD_GLITCH);
  cov_route: cover property (age_r == 3'h7 && main_clk_o);
endmodule // ucs_clock_ctrl_checker

// [testbench/ucs_clock_ctrl_test.sv]
// Purpose: self-checking bench for the clock select block
// Assumes: pins toggle from a cycle counter, loop reference period 16 cycles
// Notes: select and crystal setups come from a fixed-seed xorshift
`include "ucs_defines.vh"
module ucs_clock_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  reg core_clk_i = 1'b0;
  reg rst_b_i = 1'b0;
  reg [3:0] addr_i = 4'h0;
  reg [15:0] wdata_i = 16'h0;
  reg wr_i = 1'b0;
  reg rd_i = 1'b0;
  reg lf_present_i = 1'b0;
  reg hf_present_i = 1'b0;
  reg [15:0] cyc = 16'h0;
  wire [15:0] rdata_o;
  wire [4:0] oscillator_tap_o, modulation_o;
  wire main_clk_o, subsystem_clk_o, aux_clk_o, osc_fault_nmi_o, irq_o;
  integer errors = 0;
  integer n_checks = 0;
  integer i, n;
  reg [31:0] s = 32'hFD15;
  reg [15:0] q, f, ef;
  reg [5:0] v, cur;
  reg [4:0] t0;
  reg chg;
  ucs_clock_ctrl u_dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .low_freq_crystal_i(cyc[4]), .high_freq_crystal_i(cyc[1]),
    .internal_reference_osc_i(cyc[2]), .digitally_tuned_oscillator_i(cyc[0]),
    .loop_reference_clock_i(cyc[3]), .lf_present_i(lf_present_i), .hf_present_i(hf_present_i),
    .main_clk_o(main_clk_o), .subsystem_clk_o(subsystem_clk_o), .aux_clk_o(aux_clk_o),
    .oscillator_tap_o(oscillator_tap_o), .modulation_o(modulation_o),
    .osc_fault_nmi_o(osc_fault_nmi_o), .irq_o(irq_o));
  initial forever #50 core_clk_i = ~core_clk_i;
  // source pins; the tuned oscillator gives 8 rising edges per reference period
  always @(posedge core_clk_i) cyc <= cyc + 16'h1;
  function [31:0] xs(input [31:0] x);
    reg [31:0] t;
    begin
      t = x ^ (x << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  // v: [1] lf enable [2] hf enable [3] nmi enable [4] lf present [5] hf present
  function [15:0] fault_exp(input c, input [5:0] w);
    reg lf, hf;
    begin
      lf = (c && !(w[1] && w[4])) || (w[1] && !w[4]);
      hf = (c && !(w[2] && w[5])) || (w[2] && !w[5]);
      fault_exp = {13'h0, lf | hf, hf, lf};
    end
  endfunction
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("Error %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // one strobe cycle, then read data is taken in the cycle after
  task bus(input w, input [3:0] a, input [15:0] d);
    begin
      @(posedge core_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= w;
      rd_i <= !w;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
      rd_i <= 1'b0;
      #1 q = rdata_o;
    end
  endtask
  task rchk(input string nm, input [3:0] a, input [15:0] e);
    begin
      bus(1'b0, a, 16'h0);
      chk(nm, e, q);
    end
  endtask
  task wait_mod(input [4:0] m, input integer lim);
    begin
      n = 0;
      while (modulation_o !== m && n < lim) begin
        @(posedge core_clk_i);
        #1 n = n + 1;
      end
      chk("mod wait", {11'h0, m}, {11'h0, modulation_o});
      if (n >= lim)
        summarize;
    end
  endtask
  task do_reset;
    begin
      rst_b_i <= 1'b0;
      repeat (5) @(posedge core_clk_i);
      rst_b_i <= 1'b1;
      rchk("sel", `UCS_A_SEL, 16'h0024);
    end
  endtask
  task summarize;
    begin
      if (errors == 0 && n_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    do_reset;
    rchk("target", `UCS_A_TARGET, 16'h0131);
    rchk("loop", `UCS_A_LOOP, 16'h0010);
    bus(1'b1, 4'hF, 16'hFFFF);
    rchk("unmapped", 4'hF, 16'h0000);
    bus(1'b1, `UCS_A_IMASK, 16'h0002);
    cur = 6'h24;
    // random switching; a full crystal setup and a same-value write as corners
    for (i = 0; i < 12; i = i + 1) begin
      s = xs(s);
      v = (i == 5) ? 6'h3E : {s[5:1], 1'b0};
      @(posedge core_clk_i);
      lf_present_i <= v[4];
      hf_present_i <= v[5];
      bus(1'b1, `UCS_A_CTRL, {12'h0, v[3:0]});
      bus(1'b1, `UCS_A_FAULT, 16'h0003);
      rchk("fault held", `UCS_A_FAULT, fault_exp(1'b0, v));
      bus(1'b1, `UCS_A_ISTAT, 16'h0007);
      f = (i == 7) ? {10'h0, cur} : {10'h0, s[11:6]};
      chg = f[5:0] != cur;
      ef = fault_exp(chg, v);
      bus(1'b1, `UCS_A_SEL, f);
      chk("nmi", {15'h0, ef[2] & v[3]}, {15'h0, osc_fault_nmi_o});
      chk("irq", {15'h0, chg}, {15'h0, irq_o});
      rchk("fault", `UCS_A_FAULT, ef);
      rchk("sel", `UCS_A_SEL, f);
      cur = f[5:0];
    end
    bus(1'b1, `UCS_A_IMASK, 16'h0000);
    chk("irq masked", 16'h0, {15'h0, irq_o});
    bus(1'b1, `UCS_A_CTRL, 16'h0001);
    bus(1'b1, `UCS_A_FAULT, 16'h0003);
    bus(1'b1, `UCS_A_ISTAT, 16'h0007);
    wait_mod(`UCS_MOD_MAX, 1000);
    t0 = oscillator_tap_o;
    wait_mod(`UCS_MOD_GLITCH, 40);
    chk("tap roll", {11'h0, t0 + 5'h1}, {11'h0, oscillator_tap_o});
    wait_mod(5'h00, 400);
    chk("glitch span", 16'h1, {15'h0, n >= 224 && n <= 256});
    bus(1'b1, `UCS_A_TARGET, 16'h0008);
    n = 0;
    q = 16'h0;
    while (q[`UCS_L_SETTLED] !== 1'b1 && n < 9000) begin
      bus(1'b0, `UCS_A_LOOP, 16'h0);
      n = n + 1;
    end
    chk("settled", 16'h1, {15'h0, q[`UCS_L_SETTLED]});
    rchk("settle event", `UCS_A_ISTAT, 16'h0004);
    bus(1'b1, `UCS_A_CTRL, 16'h0000);
    rchk("meas", `UCS_A_MEAS, 16'h0008);
    do_reset;
    summarize;
  end
endmodule // ucs_clock_ctrl_test
bind ucs_clock_ctrl ucs_clock_ctrl_checker u_chk (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .low_freq_crystal_i(low_freq_crystal_i),
  .internal_reference_osc_i(internal_reference_osc_i), .high_freq_crystal_i(high_freq_crystal_i),
  .digitally_tuned_oscillator_i(digitally_tuned_oscillator_i), .main_clk_o(main_clk_o),
  .subsystem_clk_o(subsystem_clk_o), .aux_clk_o(aux_clk_o), .modulation_o(modulation_o),
  .oscillator_tap_o(oscillator_tap_o), .osc_fault_nmi_o(osc_fault_nmi_o));
